//--- include/cdpram_pkg.sv
// Package for the configurable dual-port RAM module: shapes, register map,
// pin carriers and the address-to-lane mapping shared by the module's logic.
// Assumes a 32-bit APB register bus and a single 100 MHz pclk domain.
package cdpram_pkg;

  // Storage size and module count in the device
  localparam int unsigned CDPRAM_BITS        = 1152;
  localparam int unsigned CDPRAM_NUM_MODULES = 14;
  localparam int unsigned CDPRAM_DATA_W      = 18;
  localparam int unsigned CDPRAM_ADDR_W      = 9;
  localparam int unsigned CDPRAM_ROWS        = 64;
  localparam int unsigned CDPRAM_ROW_IDX_W   = 6;

  // Clock rate and sampling depth of the pin synchronisers
  localparam int unsigned CDPRAM_PCLK_MHZ    = 100;
  localparam int unsigned CDPRAM_SYNC_STAGES = 2;

  // Shape select codes
  typedef enum logic [1:0] {
    CDPRAM_SHAPE_64X18  = 2'h0,
    CDPRAM_SHAPE_128X9  = 2'h1,
    CDPRAM_SHAPE_256X4  = 2'h2,
    CDPRAM_SHAPE_512X2  = 2'h3
  } cdpram_shape_t;

  // Lane masks per shape, before shifting
  localparam logic [17:0] CDPRAM_MASK_18 = 18'h3FFFF;
  localparam logic [17:0] CDPRAM_MASK_9  = 18'h001FF;
  localparam logic [17:0] CDPRAM_MASK_4  = 18'h0000F;
  localparam logic [17:0] CDPRAM_MASK_2  = 18'h00003;

  // Register map (byte addresses)
  localparam int unsigned CDPRAM_PADDR_W     = 12;
  localparam logic [11:0] CDPRAM_CTRL_OFF    = 12'h000;
  localparam logic [11:0] CDPRAM_STATUS_OFF  = 12'h004;
  localparam logic [11:0] CDPRAM_WRCNT_OFF   = 12'h008;

  // Control register fields and reset value
  localparam int unsigned CDPRAM_CTRL_SHAPE_LSB = 0;
  localparam int unsigned CDPRAM_CTRL_BYPASS    = 2;
  localparam int unsigned CDPRAM_CTRL_W         = 3;
  localparam logic [2:0]  CDPRAM_CTRL_RESET     = 3'h0;

  // Write counter width and reset value
  localparam int unsigned CDPRAM_WRCNT_W     = 16;
  localparam logic [15:0] CDPRAM_WRCNT_RESET = 16'h0000;
  localparam logic [17:0] CDPRAM_RDATA_RESET = 18'h00000;

  // Write port pins
  typedef struct packed {
    logic        en;
    logic [8:0]  addr;
    logic [17:0] data;
  } cdpram_wport_t;

  // Read port pins
  typedef struct packed {
    logic        read_strobe_enable;
    logic [8:0]  addr;
  } cdpram_rport_t;

  // Where a shaped address lives inside the 64x18 store
  typedef struct packed {
    logic [5:0]  row;
    logic [4:0]  shift;
    logic [17:0] mask;
  } cdpram_loc_t;

  // Upper address bits pick the row, lower ones pick the lane within it
  function automatic cdpram_loc_t cdpram_locate(cdpram_shape_t shape, logic [8:0] addr);
    cdpram_loc_t loc;
    loc = '0;
    unique case (shape)
      CDPRAM_SHAPE_64X18:
      begin
        loc.row   = addr[5:0];
        loc.shift = 5'h00;
        loc.mask  = CDPRAM_MASK_18;
      end
      CDPRAM_SHAPE_128X9:
      begin
        loc.row   = addr[6:1];
        loc.shift = addr[0] ? 5'h09 : 5'h00;
        loc.mask  = CDPRAM_MASK_9 << loc.shift;
      end
      CDPRAM_SHAPE_256X4:
      begin
        loc.row   = addr[7:2];
        loc.shift = {1'b0, addr[1:0], 2'b00};
        loc.mask  = CDPRAM_MASK_4 << loc.shift;
      end
      CDPRAM_SHAPE_512X2:
      begin
        loc.row   = addr[8:3];
        loc.shift = {1'b0, addr[2:0], 1'b0};
        loc.mask  = CDPRAM_MASK_2 << loc.shift;
      end
    endcase
    return loc;
  endfunction : cdpram_locate

endpackage : cdpram_pkg

//--- core/cdpram_store.sv
// Storage array of the dual-port RAM module: 64 rows of 18 bits.
// Assumes the caller supplies row index, lane mask and aligned write data.
`timescale 1ns/10ps
`default_nettype none

module cdpram_store
  import cdpram_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        wr_fire,
  input  wire logic [5:0]  wr_row,
  input  wire logic [17:0] wr_mask,
  input  wire logic [17:0] wr_data,
  input  wire logic [5:0]  rd_row,
  output logic      [17:0] rd_row_data
);

  // No reset: contents are undefined until written, like real RAM
  logic [17:0] mem [0:CDPRAM_ROWS-1];

  // Masked row update so other lanes of the row stay intact
  always_ff @(posedge clk)
  begin
    if (wr_fire)
    begin
      mem[wr_row] <= (mem[wr_row] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // Read sees the row before any same-edge write, so a word is never torn
  assign rd_row_data = mem[rd_row];

endmodule : cdpram_store

`default_nettype wire

//--- core/cdpram_top.sv
// Configurable dual-port RAM module: one 1,152-bit store in four shapes,
// a write port and a read port each strobed by its own clock pin.
// Assumes the port pins come from fabric logic outside the pclk domain and
// that software sets shape and read bypass over APB.
//
// Functional notes
// - Each module stores 1,152 bits; fourteen exist.
// - Two mode bits pick one of four shapes.
// - Read and write ports have separate clocks.
// - Writes clocked; reads clocked or flow-through.
// - Each port has 18 data, 9 address lines.
// - Shape decides which address and data lines count.
// - Write enable gates the write clock.
// - Read enable gates clock, or enables flow-through.
`timescale 1ns/10ps
`default_nettype none

module cdpram_top
  import cdpram_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  wr_clk,
  input  wire cdpram_pkg::cdpram_wport_t wport,
  input  wire logic                  rd_clk,
  input  wire cdpram_pkg::cdpram_rport_t rport,
  output logic      [17:0]           rdata
);

  // Pin synchronisers: stage 1 feeds only stage 2; stage 3 is edge history
  cdpram_wport_t wport_s1_q, wport_s1_d;
  cdpram_wport_t wport_s2_q, wport_s2_d;
  cdpram_rport_t rport_s1_q, rport_s1_d;
  cdpram_rport_t rport_s2_q, rport_s2_d;
  logic [2:0]    wclk_q, wclk_d;
  logic [2:0]    rclk_q, rclk_d;

  // Register file state
  logic [2:0]    ctrl_q, ctrl_d;
  logic [15:0]   wrcnt_q, wrcnt_d;
  logic [31:0]   prdata_q, prdata_d;
  logic          perr_q, perr_d;
  logic [17:0]   rdata_q, rdata_d;

  // Datapath signals
  cdpram_shape_t shape;
  logic          read_bypass_select;
  cdpram_loc_t   wloc;
  cdpram_loc_t   rloc;
  logic          wr_edge;
  logic          rd_edge;
  logic          wr_fire;
  logic          rd_fire;
  logic [17:0]   wr_aligned;
  logic [17:0]   rd_row_data;
  logic [17:0]   rd_word;
  logic          apb_setup;
  logic          apb_access;
  logic          hit_ctrl;
  logic          hit_status;
  logic          hit_wrcnt;

  // Two flops on every pin; the third clock stage only remembers the last level
  always_comb
  begin
    wport_s1_d = wport;
    wport_s2_d = wport_s1_q;
    rport_s1_d = rport;
    rport_s2_d = rport_s1_q;
    wclk_d     = {wclk_q[1:0], wr_clk};
    rclk_d     = {rclk_q[1:0], rd_clk};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wport_s1_q <= '0;
      wport_s2_q <= '0;
      rport_s1_q <= '0;
      rport_s2_q <= '0;
      wclk_q     <= 3'h0;
      rclk_q     <= 3'h0;
    end
    else
    begin
      wport_s1_q <= wport_s1_d;
      wport_s2_q <= wport_s2_d;
      rport_s1_q <= rport_s1_d;
      rport_s2_q <= rport_s2_d;
      wclk_q     <= wclk_d;
      rclk_q     <= rclk_d;
    end
  end

  // Rising edges of the port clocks, seen from the second stage onward
  assign wr_edge = wclk_q[1] & ~wclk_q[2];
  assign rd_edge = rclk_q[1] & ~rclk_q[2];

  // Shape and read mode come from the control register
  assign shape  = cdpram_shape_t'(ctrl_q[CDPRAM_CTRL_SHAPE_LSB +: 2]);
  assign read_bypass_select = ctrl_q[CDPRAM_CTRL_BYPASS];

  // Map both port addresses into the store; unused upper lines drop out
  assign wloc = cdpram_locate(shape, wport_s2_q.addr);
  assign rloc = cdpram_locate(shape, rport_s2_q.addr);

  // Write only on a write-clock edge while the enable is held
  assign wr_fire    = wr_edge & wport_s2_q.en;
  assign wr_aligned = 18'(wport_s2_q.data << wloc.shift);

  cdpram_store u_store
  (
    .clk         (pclk),
    .wr_fire     (wr_fire),
    .wr_row      (wloc.row),
    .wr_mask     (wloc.mask),
    .wr_data     (wr_aligned),
    .rd_row      (rloc.row),
    .rd_row_data (rd_row_data)
  );

  // Extract the addressed lane; data lines above the shape's width read zero
  assign rd_word = 18'((rd_row_data & rloc.mask) >> rloc.shift);

  // Clocked read on a gated edge, or flow-through while enabled in bypass
  assign rd_fire = read_bypass_select ? rport_s2_q.read_strobe_enable
                                      : (rd_edge & rport_s2_q.read_strobe_enable);

  // Read data held in a flop; it keeps its last word while not enabled
  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_fire)
    begin
      rdata_d = rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= CDPRAM_RDATA_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // APB decode; only exact word offsets hit a register
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  assign hit_ctrl   = (paddr == CDPRAM_CTRL_OFF);
  assign hit_status = (paddr == CDPRAM_STATUS_OFF);
  assign hit_wrcnt  = (paddr == CDPRAM_WRCNT_OFF);

  // Read data and error are captured in setup, so access answers at once
  always_comb
  begin
    ctrl_d   = ctrl_q;
    wrcnt_d  = wrcnt_q;
    prdata_d = prdata_q;
    perr_d   = perr_q;
    if (wr_fire)
    begin
      wrcnt_d = wrcnt_q + 16'h0001; // Wraps; software takes differences
    end
    if (apb_setup)
    begin
      perr_d   = ~(hit_ctrl | hit_status | hit_wrcnt);
      prdata_d = 32'h00000000;
      if (hit_ctrl)
      begin
        prdata_d[CDPRAM_CTRL_W-1:0] = ctrl_q;
      end
      if (hit_status)
      begin
        prdata_d[CDPRAM_DATA_W-1:0] = rdata_q;
      end
      if (hit_wrcnt)
      begin
        prdata_d[CDPRAM_WRCNT_W-1:0] = wrcnt_q;
      end
    end
    // Shape changes take effect at once; stored bits are not rearranged
    if (apb_access && pwrite && hit_ctrl)
    begin
      ctrl_d = pwdata[CDPRAM_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= CDPRAM_CTRL_RESET;
      wrcnt_q  <= CDPRAM_WRCNT_RESET;
      prdata_q <= 32'h00000000;
      perr_q   <= 1'b0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      wrcnt_q  <= wrcnt_d;
      prdata_q <= prdata_d;
      perr_q   <= perr_d;
    end
  end

  // Zero wait states: ready in the first access cycle
  assign pready  = apb_access;
  assign pslverr = apb_access & perr_q;
  assign prdata  = prdata_q;

endmodule : cdpram_top

`default_nettype wire

//--- verification/cdpram_asserts.sv
// Checker for the RAM module ports: APB answers and read word timing.
// Bound to the top from the bench; sees top ports only.
`timescale 1ns/10ps
`default_nettype none
module cdpram_asserts
  import cdpram_pkg::*;
(
  input wire logic [11:0] paddr,
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rd_clk,
  input wire cdpram_pkg::cdpram_rport_t rport,
  input wire logic [17:0] rdata
);
  localparam logic [17:0] LM [4] = '{CDPRAM_MASK_18, CDPRAM_MASK_9, CDPRAM_MASK_4, CDPRAM_MASK_2};
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic acc;
  logic unmap;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow of shape and bypass, as the register is not visible here
  always_comb
  begin
    acc = psel && penable;
    unmap = !(paddr inside {CDPRAM_CTRL_OFF, CDPRAM_STATUS_OFF, CDPRAM_WRCNT_OFF});
    ctrl_d = (acc && pwrite && paddr == CDPRAM_CTRL_OFF) ? pwdata[2:0] : ctrl_q;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= 3'h0;
    else
      ctrl_q <= ctrl_d;
  end
  chk_ready_access: assert property (acc |-> pready)
    else $error("pready low in access");
  chk_ready_idle: assert property (!acc |-> !pready)
    else $error("pready high when idle");
  chk_err_unmapped: assert property (acc && unmap |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (acc && !unmap |-> !pslverr)
    else $error("mapped access refused");
  chk_hold_disabled: assert property ((!rport.read_strobe_enable) [*5] |=> $stable(rdata))
    else $error("rdata moved with enable low");
  chk_clock_gate: assert property ((!ctrl_q[2] && !rd_clk) [*5] |=> $stable(rdata))
    else $error("clocked read moved with no clock");
  chk_lane_zero: assert property ($changed(rdata) |-> (rdata & ~LM[ctrl_q[1:0]]) == 18'h0)
    else $error("unused read lines set");
  chk_status_mirror: assert property (psel && !penable && !pwrite && paddr == 12'h004
    |=> prdata == {14'h0, $past(rdata)})
    else $error("status differs from read word");
endmodule : cdpram_asserts
`default_nettype wire

//--- verification/cdpram_fabric.sv
// Fabric logic model driving the RAM module's write and read pins.
// Calls start just after a rising pclk edge; gap sets how slow it is.
`timescale 1ns/10ps
`default_nettype none
module cdpram_fabric
  import cdpram_pkg::*;
(
  input wire logic pclk,
  output var logic wr_clk,
  output var cdpram_pkg::cdpram_wport_t wport,
  output var logic rd_clk,
  output var cdpram_pkg::cdpram_rport_t rport,
  output var logic rd_done
);
  int gap = 3; // Below 1 the pins lack setup before the clock pin
  // Pin clocks rest low between frames
  initial
  begin
    {wr_clk, rd_clk, rd_done} = 3'h0;
    wport = '0;
    rport = '0;
  end
  // Write frame; e stands for this module's decoded select, and a goes
  // unchanged to every module that holds a slice of a widened word
  task automatic write(input logic [8:0] a, input logic [17:0] d, input logic e);
    wport <= '{e, a, d};
    repeat (gap) @(posedge pclk);
    wr_clk <= 1'b1;
    repeat (gap) @(posedge pclk);
    wr_clk <= 1'b0;
    repeat (2) @(posedge pclk);
    wport <= '{1'b0, ~a, ~d}; // Released lines flip, never stale
    @(posedge pclk);
  endtask : write
  // Read frame; c low leaves the enable up with no clock pulse
  task automatic read(input logic [8:0] a, input logic e, input logic c);
    rport <= '{e, a};
    repeat (gap) @(posedge pclk);
    rd_clk <= c;
    repeat (gap) @(posedge pclk);
    rd_clk <= 1'b0;
    repeat (gap) @(posedge pclk);
    if (c)
      rport <= '{1'b0, ~a};
    rd_done <= 1'b1;
    @(posedge pclk);
    rd_done <= 1'b0;
  endtask : read
endmodule : cdpram_fabric
`default_nettype wire

//--- verification/cdpram_top_tb.sv
// Bench top for the RAM module: APB master, fabric model, queued checks.
// Assumes the checker and fabric model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module cdpram_top_tb
  import cdpram_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic wr_clk, rd_clk, rd_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [17:0] rdata, d0, d1;
  logic [8:0] a;
  cdpram_wport_t wport;
  cdpram_rport_t rport;
  logic [31:0] qr[$], qa[$];
  logic        qe[$];
  logic [17:0] mk[4] = '{CDPRAM_MASK_18, CDPRAM_MASK_9, CDPRAM_MASK_4, CDPRAM_MASK_2};
  int fail_count = 0, n_tests = 0, cyc = 0;
  integer seed = 32'h2E36C679;
  cdpram_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .wr_clk, .wport, .rd_clk, .rport, .rdata);
  cdpram_fabric fab_u (.pclk, .wr_clk, .wport, .rd_clk, .rport, .rd_done);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    // Any offset outside the map must be refused with an error
    qe.push_back(!(ad inside {CDPRAM_CTRL_OFF, CDPRAM_STATUS_OFF, CDPRAM_WRCNT_OFF}));
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask : apb
  task automatic rd32(input logic [11:0] ad, input logic [31:0] e);
    qa.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask : rd32
  // Each result that shows takes the oldest note; also bounds the run
  always @(posedge pclk)
  begin
    cyc++;
    if (rd_done === 1'b1)
      cmp("rdata", qr.pop_front(), {14'h0, rdata});
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp("prdata", qa.pop_front(), prdata);
    if (psel && penable && pready === 1'b1)
      cmp("pslverr", {31'h0, qe.pop_front()}, {31'h0, pslverr});
    if (cyc == 3000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd32(12'h000, 32'h0);
    rd32(12'h00C, 32'h0);
    apb(1'b1, 12'h008, 32'h00001234);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 12'h000, 32'(s));
      a = 9'($random(seed));
      d0 = 18'($random(seed));
      d1 = 18'($random(seed));
      fab_u.write(a, d0, 1'b1);
      fab_u.write(a ^ 9'h001, d1, 1'b1);
      fab_u.write(a, ~d0, 1'b0);
      qr.push_back(d0 & mk[s]);
      fab_u.read(a | 9'(9'h1FF << (6 + s)), 1'b1, 1'b1);
      qr.push_back(d1 & mk[s]);
      fork
        fab_u.read(a ^ 9'h001, 1'b1, 1'b1);
        fab_u.write(a ^ 9'h002, d0, 1'b1);
      join
    end
    fab_u.gap = 5;
    apb(1'b1, 12'h000, 32'h00000004);
    fab_u.write(9'h015, d0, 1'b1);
    qr.push_back(d0);
    fab_u.read(9'h015, 1'b1, 1'b0);
    fab_u.write(9'h015, d1, 1'b1);
    qr.push_back(d1);
    fab_u.read(9'h015, 1'b1, 1'b0);
    qr.push_back(d1);
    fab_u.read(9'h000, 1'b0, 1'b1);
    rd32(12'h004, {14'h0, d1});
    apb(1'b1, 12'h000, 32'h0);
    fab_u.write(9'h015, d0, 1'b1);
    qr.push_back(d1);
    fab_u.read(9'h015, 1'b1, 1'b0);
    qr.push_back(d0);
    fab_u.read(9'h015, 1'b1, 1'b1);
    rd32(12'h008, 32'h0000000F);
    // Write and read of one word on the same edge: the old word comes back whole
    qr.push_back(d0);
    fork
      fab_u.read(9'h015, 1'b1, 1'b1);
      fab_u.write(9'h015, d1, 1'b1);
    join
    qr.push_back(d1);
    fab_u.read(9'h015, 1'b1, 1'b1);
    repeat (4) @(posedge pclk);
    tally_and_finish();
  end
endmodule : cdpram_top_tb
bind cdpram_top cdpram_asserts chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .rd_clk, .rport, .rdata);
`default_nettype wire
